// file: rtl/mlam_top.sv
// Monitor result formatting, limit checks, resistor look-up and address map.
//
// Notes on behaviour
// [RULE1] Results are 16-bit words, measurement left-justified.
// [RULE2] Low-resistance variant zeroes three result LSBs.
// [RULE3] Channels refresh in fixed round-robin order.
// [RULE4] Results checked against limits without software.
// [RULE5] Supply and analog results are unsigned counts.
// [RULE6] Temperature is two's complement, 1/256 degree.
// [RULE7] Factory codes span documented result ranges.
// [RULE8] Indexed mode takes settings from look-up tables.
// [RULE9] Index 80h at -40, C7h at +102, clamped.
// [RULE10] Index disabled: resistors follow manual bytes.
// [RULE11] Single-address bit drops the auxiliary address.
// [RULE12] Main address fixed or from table byte.
// [RULE13] Upper half banked by table select byte.
// [RULE14] Auxiliary address never reaches banked tables.
// [RULE15] Single-address mode exposes extra table 00.
// [RULE16] Main protected only with pin and enable.
// [RULE17] Auxiliary and table 00 follow auxiliary enable.
// [RULE18] Programmable main address, host keeps them distinct.
// [RULE19] Protected locations ignore writes.
// [RULE20] Protect pin pulled high when left open.
// [RULE21] Resistors change only after temperature update.
`timescale 1ns/10ps
module mlam_top (
  input  wire logic                clock_in,
  input  wire logic                reset_in,
  input  wire logic                bus_req_valid_in,
  input  wire mlam_pkg::mlam_req_t bus_req_in,
  input  wire logic                write_protect_pin_in,
  input  wire logic                low_res_variant_in,
  input  wire logic                adc_valid_in,
  input  wire logic [15:0]         adc_code_in,
  output logic                     bus_done_out,
  output logic                     bus_ack_out,
  output logic [7:0]               bus_rdata_out,
  output mlam_pkg::mlam_chan_t     conv_chan_out,
  output logic [7:0]               resistor0_out,
  output logic [7:0]               resistor1_out
);

  logic [7:0]  main_mem [0:127];
  logic [15:0] res_r [0:mlam_pkg::MLAM_NUM_CHAN-1];
  logic [4:0]  upd_r;
  logic [4:0]  flag_hi_r;
  logic [4:0]  flag_lo_r;
  logic        cmp_go_r;
  logic [2:0]  cmp_chan_r;
  logic        lut_load_r;
  logic [6:0]  lut_idx_r;
  logic [7:0]  table_sel_r;
  logic [7:0]  cfg_r;
  logic [7:0]  man0_r;
  logic [7:0]  man1_r;
  logic [7:0]  main_addr_r;
  logic        wp_pin_s;
  logic        lowres_s;

  logic [7:0]  ram_rd  [0:mlam_pkg::MLAM_NUM_RAM-1];
  logic [7:0]  ram_rd2 [0:mlam_pkg::MLAM_NUM_RAM-1];
  logic [mlam_pkg::MLAM_NUM_RAM-1:0] ram_we;

  // Pin and strap levels come from outside the clock domain.
  // The pin pull-up is outside, so an open pin arrives here as a steady one.
  mlam_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({write_protect_pin_in, low_res_variant_in}),
    .sync_out ({wp_pin_s, lowres_s})
  );

  // Configuration decode.
  wire temp_index_enable      = cfg_r[mlam_pkg::MLAM_CFG_TEN];
  wire fix_addr = cfg_r[mlam_pkg::MLAM_CFG_FIX];
  wire single   = cfg_r[mlam_pkg::MLAM_CFG_SINGL];
  wire main_protect_enable     = cfg_r[mlam_pkg::MLAM_CFG_MAIN_PROTECT_ENABLE];
  wire aux_protect_enable     = cfg_r[mlam_pkg::MLAM_CFG_AUX_PROTECT_ENABLE];

  // Write protection per memory group.
  wire main_wp = wp_pin_s & main_protect_enable;  // [RULE16] [RULE20]
  wire aux_wp  = aux_protect_enable;             // [RULE17]

  // Device address decode; the main address wins if both would match.
  // Both addresses share one request path; the direction bit is ignored.
  wire [7:0] main_addr = fix_addr ? main_addr_r : mlam_pkg::MLAM_MAIN_DEF_ADDR; // [RULE12] [RULE18]
  wire [7:0] req_mem   = bus_req_in.mem_addr;
  wire       hit_main  = bus_req_in.dev_addr[7:1] == main_addr[7:1];
  wire       hit_aux   = !single && !hit_main
                         && bus_req_in.dev_addr[7:1] == mlam_pkg::MLAM_AUX_DEV_ADDR[7:1]; // [RULE11]
  wire       hi_area   = req_mem[7];
  wire       wr        = bus_req_valid_in & bus_req_in.write;
  wire       tbl_acc   = hit_main & hi_area;  // [RULE13] [RULE14]
  wire       main_wr   = wr & hit_main & !main_wp;  // [RULE19]

  // Table selection.
  wire sel_extra = table_sel_r == mlam_pkg::MLAM_TBL_EXTRA;
  wire sel_cfg   = table_sel_r == mlam_pkg::MLAM_TBL_CFG;
  wire sel_lut0  = table_sel_r == mlam_pkg::MLAM_TBL_LUT0;
  wire sel_lut1  = table_sel_r == mlam_pkg::MLAM_TBL_LUT1;
  wire sel_aux   = (table_sel_r == mlam_pkg::MLAM_TBL_AUX) && !single;

  // Write enables of the byte memories and flip-flop registers.
  // Table 00 and the auxiliary memory answer to the auxiliary protect bit only.
  assign ram_we[0] = wr & tbl_acc & sel_extra & single & !aux_wp;  // [RULE15] [RULE17]
  assign ram_we[1] = main_wr & hi_area & sel_cfg;
  assign ram_we[2] = main_wr & hi_area & sel_lut0;
  assign ram_we[3] = main_wr & hi_area & sel_lut1;
  assign ram_we[4] = wr & !aux_wp & ((hit_aux & !hi_area) | (tbl_acc & sel_aux)); // [RULE17]
  wire   low_we    = main_wr & !hi_area;
  wire   cfg_wr    = ram_we[1];
  wire   tsel_we   = low_we & (req_mem == mlam_pkg::MLAM_TABLE_SEL_OFS);
  wire   upd_we    = low_we & (req_mem == mlam_pkg::MLAM_UPDATE_OFS);

  // One memory per table plus the auxiliary memory.
  genvar g;
  generate
    for (g = 0; g < mlam_pkg::MLAM_NUM_RAM; g++) begin : g_ram
      mlam_byte_ram u_ram (
        .clock_in   (clock_in),
        .write_in   (ram_we[g]),
        .addr_in    (req_mem[6:0]),
        .wdata_in   (bus_req_in.wdata),
        .addr2_in   (lut_idx_r),
        .rdata_out  (ram_rd[g]),
        .rdata2_out (ram_rd2[g])
      );
    end
  endgenerate

  // Measured value bytes, most significant byte first.
  wire       meas_area = (req_mem[7:4] == mlam_pkg::MLAM_MEAS_NIBBLE)
                         && (req_mem[3:0] <= mlam_pkg::MLAM_MEAS_LAST);
  wire [2:0] meas_ch   = req_mem[3:1];
  wire [7:0] meas_byte = req_mem[0] ? res_r[meas_ch][7:0] : res_r[meas_ch][15:8];

  // Status bytes of updates and limit flags.
  wire [7:0] upd_byte   = {upd_r[0], upd_r[1], upd_r[2], upd_r[3], upd_r[4], 3'h0};
  wire [7:0] flag0_byte = {flag_hi_r[0], flag_lo_r[0], flag_hi_r[1], flag_lo_r[1],
                           flag_hi_r[2], flag_lo_r[2], flag_hi_r[3], flag_lo_r[3]};
  wire [7:0] flag1_byte = {flag_hi_r[4], flag_lo_r[4], 6'h00};

  // Read selection for the lower main area.
  wire [7:0] low_rd =
    meas_area                                 ? meas_byte   :
    (req_mem == mlam_pkg::MLAM_UPDATE_OFS)    ? upd_byte    :
    (req_mem == mlam_pkg::MLAM_FLAG0_OFS)     ? flag0_byte  :
    (req_mem == mlam_pkg::MLAM_FLAG1_OFS)     ? flag1_byte  :
    (req_mem == mlam_pkg::MLAM_TABLE_SEL_OFS) ? table_sel_r :
                                                main_mem[req_mem[6:0]];

  // Read selection for the configuration table.
  wire [7:0] cfg_rd =
    (req_mem == mlam_pkg::MLAM_R0_MAN_OFS)    ? man0_r      :
    (req_mem == mlam_pkg::MLAM_R1_MAN_OFS)    ? man1_r      :
    (req_mem == mlam_pkg::MLAM_MAIN_ADDR_OFS) ? main_addr_r :
    (req_mem == mlam_pkg::MLAM_CFG_OFS)       ? cfg_r       :
                                                ram_rd[1];

  // Read selection for the banked area; unmapped tables read zero.
  wire [7:0] tbl_rd =
    (sel_extra && single) ? ram_rd[0] :  // [RULE15]
    sel_cfg               ? cfg_rd    :
    sel_lut0              ? ram_rd[2] :
    sel_lut1              ? ram_rd[3] :
    sel_aux               ? ram_rd[4] :
                            8'h00;

  wire [7:0] rd_byte = hit_main ? (hi_area ? tbl_rd : low_rd) :
                       (hit_aux && !hi_area) ? ram_rd[4] : 8'h00;  // [RULE14]

  // Lower main area storage; reserved and read-only bytes are shadowed on read.
  // Limit bytes live here too, so the compare reads them straight from this array.
  always_ff @(posedge clock_in) begin
    if (low_we) begin
      main_mem[req_mem[6:0]] <= bus_req_in.wdata;
    end
  end

  // Bus answer one cycle after each request.
  // The read byte holds between requests so a slow serial slave can shift it out.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      bus_done_out  <= 1'b0;
      bus_ack_out   <= 1'b0;
      bus_rdata_out <= 8'h00;
    end else begin
      bus_done_out  <= bus_req_valid_in;
      bus_ack_out   <= bus_req_valid_in & (hit_main | hit_aux);
      bus_rdata_out <= bus_req_valid_in ? rd_byte : bus_rdata_out;
    end
  end

  // Software registers held in flip-flops.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      table_sel_r <= mlam_pkg::MLAM_TABLE_SEL_RST;
      cfg_r       <= mlam_pkg::MLAM_CFG_RST;
      man0_r      <= mlam_pkg::MLAM_MAN_RST;
      man1_r      <= mlam_pkg::MLAM_MAN_RST;
      main_addr_r <= mlam_pkg::MLAM_MAIN_DEF_ADDR;
    end else begin
      if (tsel_we) table_sel_r <= bus_req_in.wdata;  // [RULE13]
      if (cfg_wr && req_mem == mlam_pkg::MLAM_CFG_OFS) cfg_r <= bus_req_in.wdata;
      if (cfg_wr && req_mem == mlam_pkg::MLAM_R0_MAN_OFS) man0_r <= bus_req_in.wdata;
      if (cfg_wr && req_mem == mlam_pkg::MLAM_R1_MAN_OFS) man1_r <= bus_req_in.wdata;
      if (cfg_wr && req_mem == mlam_pkg::MLAM_MAIN_ADDR_OFS) main_addr_r <= bus_req_in.wdata;
    end
  end

  // Result formatting of the incoming conversion.
  wire [15:0] res_fmt = lowres_s ? (adc_code_in & mlam_pkg::MLAM_LOWRES_MASK) // [RULE2]
                                 : adc_code_in;  // [RULE1] [RULE5] [RULE6] [RULE7]
  wire [2:0]  cur_ch  = conv_chan_out;
  wire        last_ch = conv_chan_out == mlam_pkg::MLAM_CH_ANALOG_INPUT_3;

  // Result capture and round-robin channel advance.
  // A conversion on the last channel wraps the round robin back to temperature.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < mlam_pkg::MLAM_NUM_CHAN; i++) begin
        res_r[i] <= 16'h0000;
      end
      conv_chan_out <= mlam_pkg::MLAM_CH_TEMP;
      cmp_go_r      <= 1'b0;
      cmp_chan_r    <= 3'h0;
    end else begin
      cmp_go_r <= adc_valid_in;
      if (adc_valid_in) begin
        res_r[cur_ch] <= res_fmt;
        cmp_chan_r    <= cur_ch;
        conv_chan_out <= last_ch ? mlam_pkg::MLAM_CH_TEMP
                                 : mlam_pkg::mlam_chan_t'(cur_ch + 3'h1);  // [RULE3]
      end
    end
  end

  // Limit bytes of the channel just captured.
  wire [6:0]  lim_base = 7'(cmp_chan_r * mlam_pkg::MLAM_LIMIT_STRIDE);
  wire [6:0]  lo_base  = lim_base + 7'(mlam_pkg::MLAM_LIMIT_LO_OFS);
  wire [15:0] lim_hi   = {main_mem[lim_base], main_mem[lim_base + 7'h1]};
  wire [15:0] lim_lo   = {main_mem[lo_base], main_mem[lo_base + 7'h1]};
  wire [15:0] cmp_val  = res_r[cmp_chan_r];
  wire        is_temp  = cmp_chan_r == mlam_pkg::MLAM_CH_TEMP;
  wire        over_hi  = is_temp ? ($signed(cmp_val) > $signed(lim_hi)) : (cmp_val > lim_hi);
  wire        under_lo = is_temp ? ($signed(cmp_val) < $signed(lim_lo)) : (cmp_val < lim_lo);

  // Update bits: set by a capture, cleared by writing zero, set wins.
  wire [4:0] upd_set = adc_valid_in ? 5'(5'h01 << cur_ch) : 5'h00;
  wire [4:0] upd_keep = upd_we ? {bus_req_in.wdata[3], bus_req_in.wdata[4],
                                  bus_req_in.wdata[5], bus_req_in.wdata[6],
                                  bus_req_in.wdata[7]} : 5'h1f;

  // Flags follow each compare one cycle after the capture.
  // A flag reflects only the latest compare of its channel; it is live status.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      upd_r     <= 5'h00;
      flag_hi_r <= 5'h00;
      flag_lo_r <= 5'h00;
    end else begin
      upd_r <= (upd_r & upd_keep) | upd_set;
      if (cmp_go_r) begin
        flag_hi_r[cmp_chan_r] <= over_hi;   // [RULE4]
        flag_lo_r[cmp_chan_r] <= under_lo;  // [RULE4]
      end
    end
  end

  // Look-up index from whole degrees, clamped to the table ends.
  // Clamping is done on whole degrees before halving, so both table ends are exact.
  wire signed [8:0] deg_now = $signed({adc_code_in[15], res_fmt[15:8]});
  wire signed [8:0] deg_ofs = deg_now - mlam_pkg::MLAM_TEMP_LOW;
  wire        [6:0] idx_mid = 7'(deg_ofs >>> 1);
  wire        [6:0] idx_new = (deg_now < mlam_pkg::MLAM_TEMP_LOW)  ? 7'h00 :
                              (deg_now > mlam_pkg::MLAM_TEMP_HIGH) ? mlam_pkg::MLAM_LUT_LAST :
                                                                     idx_mid;  // [RULE9]
  wire        temp_cap = adc_valid_in && cur_ch == mlam_pkg::MLAM_CH_TEMP;

  // Index is taken with the temperature result; resistors follow a cycle later.
  // Manual mode tracks the setting bytes every cycle; indexed mode moves only on a load.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      lut_idx_r     <= 7'h00;
      lut_load_r    <= 1'b0;
      resistor0_out <= mlam_pkg::MLAM_MAN_RST;
      resistor1_out <= mlam_pkg::MLAM_MAN_RST;
    end else begin
      lut_load_r <= temp_cap;
      if (temp_cap) lut_idx_r <= idx_new;  // [RULE21]
      if (!temp_index_enable) begin
        resistor0_out <= man0_r;  // [RULE10]
        resistor1_out <= man1_r;  // [RULE10]
      end else if (lut_load_r) begin
        resistor0_out <= ram_rd2[2];  // [RULE8] [RULE21]
        resistor1_out <= ram_rd2[3];  // [RULE8] [RULE21]
      end
    end
  end

endmodule

// file: shared/mlam_pkg.sv
// Constants, types and the address map of the monitor, look-up and address block.
package mlam_pkg;

  // Device addresses on the 2-wire bus, as full bytes with the direction bit clear.
  localparam logic [7:0] MLAM_AUX_DEV_ADDR  = 8'ha0;
  localparam logic [7:0] MLAM_MAIN_DEF_ADDR = 8'ha2;

  // Main device byte offsets below the banked area.
  localparam logic [7:0] MLAM_LIMIT_STRIDE  = 8'h08;
  localparam logic [7:0] MLAM_LIMIT_LO_OFS  = 8'h02;
  localparam logic [3:0] MLAM_MEAS_NIBBLE   = 4'h6;
  localparam logic [3:0] MLAM_MEAS_LAST     = 4'h9;
  localparam logic [7:0] MLAM_UPDATE_OFS    = 8'h6f;
  localparam logic [7:0] MLAM_FLAG0_OFS     = 8'h70;
  localparam logic [7:0] MLAM_FLAG1_OFS     = 8'h71;
  localparam logic [7:0] MLAM_TABLE_SEL_OFS = 8'h7f;

  // Banked table offsets and table numbers.
  localparam logic [7:0] MLAM_R0_MAN_OFS    = 8'h82;
  localparam logic [7:0] MLAM_R1_MAN_OFS    = 8'h83;
  localparam logic [7:0] MLAM_CFG_OFS       = 8'h89;
  localparam logic [7:0] MLAM_MAIN_ADDR_OFS = 8'h8c;
  localparam logic [7:0] MLAM_TBL_EXTRA     = 8'h00;
  localparam logic [7:0] MLAM_TBL_CFG       = 8'h01;
  localparam logic [7:0] MLAM_TBL_LUT0      = 8'h02;
  localparam logic [7:0] MLAM_TBL_LUT1      = 8'h03;
  localparam logic [7:0] MLAM_TBL_AUX       = 8'h04;

  // Bit positions inside the configuration byte.
  localparam int MLAM_CFG_TEN   = 0;
  localparam int MLAM_CFG_FIX   = 1;
  localparam int MLAM_CFG_SINGL = 2;
  localparam int MLAM_CFG_MAIN_PROTECT_ENABLE  = 3;
  localparam int MLAM_CFG_AUX_PROTECT_ENABLE  = 4;

  // Reset values of the flip-flop registers.
  localparam logic [7:0] MLAM_TABLE_SEL_RST = 8'h01;
  localparam logic [7:0] MLAM_CFG_RST       = 8'h00;
  localparam logic [7:0] MLAM_MAN_RST       = 8'h00;

  // Look-up indexing: degrees of the first and last entry and the index of the last entry.
  localparam logic signed [8:0] MLAM_TEMP_LOW  = -9'sd40;
  localparam logic signed [8:0] MLAM_TEMP_HIGH = 9'sd102;
  localparam logic [6:0]        MLAM_LUT_LAST  = 7'h47;
  localparam logic [15:0]       MLAM_LOWRES_MASK = 16'hfff8;

  localparam int MLAM_NUM_CHAN = 5;
  localparam int MLAM_NUM_RAM  = 5;

  // Channels in the order in which they are refreshed.
  typedef enum logic [2:0] {
    MLAM_CH_TEMP = 3'b000,
    MLAM_CH_VCC  = 3'b001,
    MLAM_CH_ANALOG_INPUT_1 = 3'b010,
    MLAM_CH_ANALOG_INPUT_2 = 3'b011,
    MLAM_CH_ANALOG_INPUT_3 = 3'b100
  } mlam_chan_t;

  // One byte access handed over by the 2-wire serial slave.
  typedef struct packed {
    logic [7:0] dev_addr;
    logic [7:0] mem_addr;
    logic       write;
    logic [7:0] wdata;
  } mlam_req_t;

endpackage

// file: rtl/mlam_sync.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module mlam_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // The first stage is read by the second stage only.
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// file: rtl/mlam_byte_ram.sv
// A 128 byte memory with one write port and two combinational read ports.
`timescale 1ns/10ps
module mlam_byte_ram (
  input  wire logic       clock_in,
  input  wire logic       write_in,
  input  wire logic [6:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic [6:0] addr2_in,
  output logic      [7:0] rdata_out,
  output logic      [7:0] rdata2_out
);

  logic [7:0] mem [0:127];

  // Contents stand for nonvolatile storage, so reset leaves them alone.
  always_ff @(posedge clock_in) begin
    if (write_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // Bus read and look-up read are independent.
  assign rdata_out  = mem[addr_in];
  assign rdata2_out = mem[addr2_in];

endmodule

// file: testbench/mlam_top_chk.sv
// Port-level checker for the monitor, look-up and address block.
`timescale 1ns/10ps
module mlam_top_chk (
  input wire logic                 clock_in,
  input wire logic                 reset_in,
  input wire logic                 bus_req_valid_in,
  input wire logic                 adc_valid_in,
  input wire logic                 bus_done_out,
  input wire logic                 bus_ack_out,
  input wire logic [7:0]           bus_rdata_out,
  input wire mlam_pkg::mlam_chan_t conv_chan_out,
  input wire logic [7:0]           resistor0_out,
  input wire logic [7:0]           resistor1_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // Every access is answered exactly one cycle after it is taken, and never otherwise.
  property p_done; bus_req_valid_in |=> bus_done_out; endproperty
  property p_idle; !bus_req_valid_in |=> !bus_done_out && !bus_ack_out; endproperty
  property p_ack; bus_ack_out |-> bus_done_out; endproperty
  property p_nak; bus_done_out && !bus_ack_out |-> bus_rdata_out == 8'h00; endproperty
  property p_hold; !bus_req_valid_in |=> $stable(bus_rdata_out); endproperty
  a_done: assert property (p_done)
    else $error("access not answered one cycle later");
  a_idle: assert property (p_idle)
    else $error("answer without an access");
  a_ack: assert property (p_ack)
    else $error("acknowledge outside an answer");
  a_nak: assert property (p_nak)
    else $error("unmatched address returned data");
  a_hold: assert property (p_hold)
    else $error("read byte moved without an access");

  // Channels are refreshed in a fixed round robin, advancing only on a conversion.
  property p_wrap;
    adc_valid_in && conv_chan_out == mlam_pkg::MLAM_CH_ANALOG_INPUT_3
      |=> conv_chan_out == mlam_pkg::MLAM_CH_TEMP;
  endproperty
  property p_step;
    adc_valid_in && conv_chan_out != mlam_pkg::MLAM_CH_ANALOG_INPUT_3
      |=> conv_chan_out == $past(conv_chan_out) + 3'h1;
  endproperty
  property p_still; !adc_valid_in |=> $stable(conv_chan_out); endproperty
  a_wrap: assert property (p_wrap)
    else $error("channel did not wrap to temperature");
  a_step: assert property (p_step)
    else $error("channel did not advance by one");
  a_still: assert property (p_still)
    else $error("channel moved without a conversion");

  // Resistor settings move only after a register write or a finished conversion.
  property p_res;
    $changed(resistor0_out) || $changed(resistor1_out)
      |-> $past(bus_req_valid_in, 2) || $past(adc_valid_in, 2);
  endproperty
  a_res: assert property (p_res)
    else $error("resistor changed without a cause");

  c_nak: cover property (bus_done_out && !bus_ack_out);
  c_wrap: cover property (adc_valid_in && conv_chan_out == mlam_pkg::MLAM_CH_ANALOG_INPUT_3);
  c_res: cover property ($changed(resistor0_out));
endmodule

bind mlam_top mlam_top_chk chk_i (.clock_in, .reset_in, .bus_req_valid_in, .adc_valid_in,
  .bus_done_out, .bus_ack_out, .bus_rdata_out, .conv_chan_out, .resistor0_out,
  .resistor1_out);

// file: testbench/mlam_host_model.sv
// Behavioural 2-wire host controller that hands single byte accesses to the block.
`timescale 1ns/10ps
module mlam_host_model (
  input  wire logic          clock_in,
  input  wire logic          done_in,
  input  wire logic          ack_in,
  input  wire logic [7:0]    rdata_in,
  output logic               valid_out,
  output mlam_pkg::mlam_req_t req_out
);
  // Idle bus at time zero.
  initial begin
    valid_out = 1'b0;
    req_out = '0;
  end

  // One access, raised after a falling edge and taken at the next rising edge; the
  // answer is read one cycle on and the request lines are scrambled once released.
  // Each device on the shared bus is addressed by its own distinct address.
  task automatic xfer(input logic [7:0] dev, input logic [7:0] addr, input logic wr,
                      input logic [7:0] wd, output logic ack, output logic [7:0] rd);
    @(negedge clock_in);
    valid_out = 1'b1;
    req_out = '{dev, addr, wr, wd};
    @(negedge clock_in);
    valid_out = 1'b0;
    req_out = ~req_out;
    ack = ack_in & done_in;
    rd = rdata_in;
  endtask
endmodule

// file: testbench/mlam_top_test.sv
// Self-checking bench for the monitor, look-up and address block.
`timescale 1ns/10ps
module mlam_top_test;
  logic                 clock_in;
  logic                 reset_in;
  logic                 req_valid;
  mlam_pkg::mlam_req_t  req;
  logic                 wp_pin;
  logic                 low_res;
  logic                 adc_valid;
  logic [15:0]          adc_code;
  logic                 done;
  logic                 ack;
  logic [7:0]           rdata;
  mlam_pkg::mlam_chan_t chan;
  logic [7:0]           res0;
  logic [7:0]           res1;
  logic                 ak;
  logic [7:0]           rb;
  int                   n_fail;
  int                   n_checks;

  mlam_top uut (.clock_in(clock_in), .reset_in(reset_in), .bus_req_valid_in(req_valid),
    .bus_req_in(req), .write_protect_pin_in(wp_pin), .low_res_variant_in(low_res),
    .adc_valid_in(adc_valid), .adc_code_in(adc_code), .bus_done_out(done),
    .bus_ack_out(ack), .bus_rdata_out(rdata), .conv_chan_out(chan),
    .resistor0_out(res0), .resistor1_out(res1));
  mlam_host_model h (.clock_in(clock_in), .done_in(done), .ack_in(ack),
    .rdata_in(rdata), .valid_out(req_valid), .req_out(req));

  // A 25 MHz clock.
  initial clock_in = 1'b0;
  always #20 clock_in = ~clock_in;

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] d, input logic [7:0] a, input logic [7:0] v);
    h.xfer(d, a, 1'b1, v, ak, rb);
  endtask

  task automatic rd(input logic [7:0] d, input logic [7:0] a, input logic [7:0] e);
    h.xfer(d, a, 1'b0, 8'h00, ak, rb);
    chk(rb, e);
  endtask

  task automatic cfg(input logic [7:0] v);
    wr(8'ha2, 8'h7f, 8'h01);
    wr(8'ha2, 8'h89, v);
  endtask

  task automatic pulse(input logic [15:0] c);
    @(negedge clock_in);
    adc_valid = 1'b1;
    adc_code = c;
    @(negedge clock_in);
    adc_valid = 1'b0;
    adc_code = ~c;
  endtask

  // Converts dummy results until the wanted channel is next, then the real one.
  task automatic adc(input logic [2:0] ch, input logic [15:0] code);
    for (int i = 0; i < 6 && chan !== ch; i++) pulse(16'h0000);
    if (chan !== ch) begin
      n_fail++;
      $display("unexpected at %0t: channel %0d never came round", $time, ch);
      stop_test;
    end else begin
      pulse(code);
    end
  endtask

  task automatic t_regs;
    rd(8'ha2, 8'h7f, 8'h01);
    rd(8'ha2, 8'h82, 8'h00);
    rd(8'ha2, 8'h8c, 8'ha2);
    wr(8'ha2, 8'h7f, 8'h03);
    wr(8'ha2, 8'h80, 8'ha5);
    wr(8'ha2, 8'h7f, 8'h02);
    wr(8'ha2, 8'h80, 8'h5a);
    rd(8'ha2, 8'h80, 8'h5a);
    cfg(8'h00);
    wr(8'ha2, 8'h82, 8'h3c);
    wr(8'ha2, 8'h83, 8'hc3);
    @(negedge clock_in);
    chk(res0, 8'h3c);
    chk(res1, 8'hc3);
  endtask

  task automatic t_addr;
    wr(8'ha0, 8'h05, 8'h77);
    chk({7'h0, ak}, 8'h01);
    wr(8'ha2, 8'h7f, 8'h04);
    rd(8'ha2, 8'h85, 8'h77);
    wr(8'ha0, 8'h85, 8'h11);
    rd(8'ha0, 8'h85, 8'h00);
    cfg(8'h04);
    rd(8'ha0, 8'h05, 8'h00);
    chk({7'h0, ak}, 8'h00);
    wr(8'ha2, 8'h7f, 8'h00);
    wr(8'ha2, 8'h90, 8'h66);
    rd(8'ha2, 8'h90, 8'h66);
    wr(8'ha2, 8'h7f, 8'h01);
    wr(8'ha2, 8'h8c, 8'hb4);
    wr(8'ha2, 8'h89, 8'h06);
    rd(8'ha2, 8'h7f, 8'h00);
    rd(8'hb4, 8'h7f, 8'h01);
    wr(8'hb4, 8'h89, 8'h00);
  endtask

  task automatic t_prot;
    wr(8'ha2, 8'h38, 8'h55);
    cfg(8'h08);
    wr(8'ha2, 8'h38, 8'haa);
    rd(8'ha2, 8'h38, 8'h55);
    wp_pin = 1'b0;
    repeat (3) @(negedge clock_in);
    wr(8'ha2, 8'h38, 8'haa);
    rd(8'ha2, 8'h38, 8'haa);
    cfg(8'h10);
    wr(8'ha0, 8'h05, 8'h99);
    rd(8'ha0, 8'h05, 8'h77);
    cfg(8'h00);
    wp_pin = 1'b1;
  endtask

  task automatic t_conv;
    adc(3'h0, 16'h8000);
    rd(8'ha2, 8'h60, 8'h80);
    rd(8'ha2, 8'h61, 8'h00);
    wr(8'ha2, 8'h6f, 8'h00);
    adc(3'h1, 16'h8080);
    rd(8'ha2, 8'h6f, 8'h40);
    rd(8'ha2, 8'h63, 8'h80);
    adc(3'h2, 16'hfff8);
    rd(8'ha2, 8'h65, 8'hf8);
    low_res = 1'b1;
    repeat (3) @(negedge clock_in);
    adc(3'h3, 16'hffff);
    rd(8'ha2, 8'h67, 8'hf8);
    low_res = 1'b0;
    wr(8'ha2, 8'h08, 8'h40);
    wr(8'ha2, 8'h09, 8'h00);
    wr(8'ha2, 8'h0a, 8'h00);
    wr(8'ha2, 8'h0b, 8'h00);
    adc(3'h1, 16'h5000);
    h.xfer(8'ha2, 8'h70, 1'b0, 8'h00, ak, rb);
    chk({6'h0, rb[5:4]}, 8'h02);
    adc(3'h1, 16'h3000);
    h.xfer(8'ha2, 8'h70, 1'b0, 8'h00, ak, rb);
    chk({6'h0, rb[5:4]}, 8'h00);
  endtask

  task automatic t_lut;
    wr(8'ha2, 8'h7f, 8'h02);
    wr(8'ha2, 8'h81, 8'h33);
    wr(8'ha2, 8'hc7, 8'h22);
    wr(8'ha2, 8'h80, 8'h11);
    wr(8'ha2, 8'h7f, 8'h03);
    rd(8'ha2, 8'h80, 8'ha5);
    wr(8'ha2, 8'h80, 8'h44);
    wr(8'ha2, 8'h81, 8'h66);
    wr(8'ha2, 8'hc7, 8'h55);
    cfg(8'h01);
    adc(3'h0, 16'hce00);
    @(negedge clock_in);
    chk(res0, 8'h11);
    adc(3'h0, 16'hda00);
    chk(res0, 8'h11);
    @(negedge clock_in);
    chk(res0, 8'h33);
    chk(res1, 8'h66);
    adc(3'h0, 16'h6e00);
    @(negedge clock_in);
    chk(res1, 8'h55);
    cfg(8'h00);
    @(negedge clock_in);
    chk(res0, 8'h3c);
  endtask

  // Reset for 20 cycles, then each scenario in turn.
  initial begin
    n_fail = 0;
    n_checks = 0;
    reset_in = 1'b1;
    wp_pin = 1'b1;
    low_res = 1'b0;
    adc_valid = 1'b0;
    adc_code = 16'h0000;
    repeat (20) @(negedge clock_in);
    reset_in = 1'b0;
    t_regs;
    t_addr;
    t_prot;
    t_conv;
    t_lut;
    stop_test;
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    $display("unexpected at %0t: run timed out", $time);
    stop_test;
  end
endmodule
